// ### design/afp_pkg.sv
// Package with the constants shared by the angle filter and power control block.
package afp_pkg;

   // Clock rate.
   localparam int unsigned CLK_HZ            = 25000000;

   // Slow filter shifts per select code; a larger shift gives a longer delay.
   localparam logic [3:0]  SHIFT_SF00        = 4'h6;
   localparam logic [3:0]  SHIFT_SF01        = 4'h5;
   localparam logic [3:0]  SHIFT_SF10        = 4'h4;
   localparam logic [3:0]  SHIFT_SF11        = 4'h3;

   // Step response delays for select code 00 in microseconds and select code 11 in nanoseconds.
   localparam int unsigned DELAY_SF00_US     = 2200;
   localparam int unsigned DELAY_SF11_NS     = 286000;

   // Filter update period: the 2.2 ms setting takes about 2^6 updates.
   localparam int unsigned UPDATE_PERIOD_NS  = 32000;
   localparam int unsigned UPDATE_CYCLES     = (UPDATE_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;

   // Slow-to-fast and fast-to-slow thresholds in LSB.
   localparam logic [4:0]  S2F_001           = 5'h06;
   localparam logic [4:0]  S2F_010           = 5'h07;
   localparam logic [4:0]  S2F_011           = 5'h09;
   localparam logic [4:0]  S2F_100           = 5'h12;
   localparam logic [4:0]  S2F_101           = 5'h15;
   localparam logic [4:0]  S2F_110           = 5'h18;
   localparam logic [4:0]  S2F_111           = 5'h0a;
   localparam logic [4:0]  F2S_LOW           = 5'h01;
   localparam logic [4:0]  F2S_MID           = 5'h02;
   localparam logic [4:0]  F2S_HIGH          = 5'h04;

   // Watchdog stillness window and time.
   localparam logic [11:0] WD_WINDOW_LSB     = 12'h004;
   localparam int unsigned WD_TIME_S         = 60;
   localparam longint unsigned WD_CYCLES     = longint'(WD_TIME_S) * longint'(CLK_HZ);

   // Latest time for a register write to reach the outputs.
   localparam int unsigned CFG_APPLY_US      = 1000;
   localparam int unsigned CFG_APPLY_CYCLES  = (CFG_APPLY_US * (CLK_HZ / 1000000));

   // Register offsets.
   localparam logic [3:0]  ADDR_CONFIG       = 4'h0;
   localparam logic [3:0]  ADDR_STATUS       = 4'h1;
   localparam logic [3:0]  ADDR_IRQ_STATUS   = 4'h2;
   localparam logic [3:0]  ADDR_IRQ_MASK     = 4'h3;
   localparam logic [3:0]  ADDR_MIN_FIELD    = 4'h4;
   localparam logic [3:0]  ADDR_ANGLE        = 4'h5;

   // Configuration field positions.
   localparam int unsigned POS_PM            = 0;
   localparam int unsigned POS_HYSTERESIS_SELECT          = 2;
   localparam int unsigned POS_SF            = 8;
   localparam int unsigned POS_FTH           = 10;
   localparam int unsigned POS_WD            = 13;
   localparam logic [15:0] CONFIG_RESET      = 16'h0000;
   localparam logic [7:0]  MIN_FIELD_RESET   = 8'h20;

   // Interrupt status bits.
   localparam int unsigned IRQ_MAGNET_LOST   = 0;
   localparam int unsigned IRQ_MAGNET_FOUND  = 1;
   localparam int unsigned IRQ_WD_SLEEP      = 2;
   localparam int unsigned IRQ_FAST_ON       = 3;
   localparam int unsigned IRQ_BITS          = 4;

   // Power states.
   typedef enum logic [3:0]
   {
      PWR_NORMAL = 4'b0001,
      PWR_FIRST_LOW_POWER_MODE   = 4'b0010,
      PWR_SECOND_LOW_POWER_MODE   = 4'b0100,
      PWR_LPM3   = 4'b1000
   } afp_pwr_t;

endpackage : afp_pkg

// ### design/afp_stage.sv
// Single-pole linear filter stage with a selectable shift.
`timescale 1ns/100ps
`default_nettype none

module afp_stage
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        step_en,
   input  wire logic        load,
   input  wire logic [11:0] sample,
   input  wire logic [3:0]  shift,
   output logic      [11:0] value
);

   logic [19:0] acc_reg;
   logic [19:0] sample_ext;
   logic [20:0] diff;
   logic [20:0] step;

   assign sample_ext = {sample, 8'h00};
   assign diff       = {1'b0, sample_ext} - {1'b0, acc_reg};
   assign step       = $signed(diff) >>> shift;

   always_ff @(posedge core_clk)
   begin
      if (srst)
         acc_reg <= 20'h00000;
      else if (load)
         acc_reg <= sample_ext;
      else if (step_en)
         acc_reg <= acc_reg + step[19:0];
   end

   assign value = acc_reg[19:8] + {11'h000, acc_reg[7]};

endmodule : afp_stage

`default_nettype wire

// ### design/afp_core.sv
// Angle filter, hysteresis, magnet detection and power control top module.
// How it works
// R1: Slow filter shift set by slow_filter_select; longer shift gives longer delay.
// R2: Fast threshold select zero keeps the fast filter permanently off.
// R3: Fast filter engages only when the input step exceeds the slow-to-fast level.
// R4: Thresholds decoded per select code from the fixed table.
// R5: While engaged the filter runs with the shortest slow setting shift.
// R6: Filter returns to the slow setting once error is under fast-to-slow level.
// R7: Output holds until the angle moves beyond the hysteresis band.
// R8: Weak field freezes the quadrature angle and clears magnet_present.
// R9: Power state machine follows power_mode_select and the watchdog.
// R10: Any low-power mode forces the fast filter off.
// R11: Watchdog forces deepest mode after a minute within four LSB.
// R12: Mode decode: 0X normal or first, 10 second, 11 deepest.
// R13: Register writes reach the outputs within one update period, under 1 ms.
// R14: Hysteresis code zero disables it; one to three select that many LSB.
// R15: Motion beyond four LSB restarts the watchdog and leaves forced deepest mode.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module afp_core
#(
   parameter longint unsigned WD_CYCLES = afp_pkg::WD_CYCLES
)
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic [11:0] raw_angle,
   input  wire logic [7:0]  field_strength,
   output logic      [11:0] quad_angle,
   output logic             magnet_present,
   output logic      [3:0]  power_state,
   output logic             irq
);

   logic [11:0]       angle_s1_reg;
   logic [11:0]       angle_s2_reg;
   logic [7:0]        field_s1_reg;
   logic [7:0]        field_s2_reg;
   logic [15:0]       config_register_reg;
   logic [7:0]        min_field_level_reg;
   localparam int IRQ_W = afp_pkg::IRQ_BITS;
   logic [IRQ_W-1:0]  irq_status_reg;
   logic [IRQ_W-1:0]  irq_mask_reg;
   logic [IRQ_W-1:0]  irq_event;

   logic [1:0]        power_mode_select;
   logic [1:0]        hysteresis_select;
   logic [1:0]        slow_filter_select;
   logic [2:0]        fast_threshold_select;
   logic              watchdog_enable;

   logic [15:0]       upd_cnt_reg;
   logic              upd_tick;
   logic              fast_reg;
   logic              fast_next;
   logic [3:0]        shift;
   logic [4:0]        s2f_lsb;
   logic [4:0]        f2s_lsb;
   logic [11:0]       filt_value;
   logic [11:0]       err;
   logic [11:0]       err_abs;
   logic [11:0]       hold_reg;
   logic [11:0]       hysteresis_select_diff;
   logic [11:0]       hysteresis_select_abs;
   logic [11:0]       hysteresis_select_lsb;
   logic              magnet_ok;
   logic              magnet_reg;
   logic [11:0]       wd_ref_reg;
   logic [11:0]       wd_diff;
   logic [11:0]       wd_abs;
   logic              wd_moved;
   logic [35:0]       wd_cnt_reg;
   logic              wd_sleep_reg;
   afp_pkg::afp_pwr_t pwr_reg;
   afp_pkg::afp_pwr_t pwr_next;

   assign power_mode_select     = config_register_reg[afp_pkg::POS_PM +: 2];
   assign hysteresis_select     = config_register_reg[afp_pkg::POS_HYSTERESIS_SELECT +: 2];
   assign slow_filter_select    = config_register_reg[afp_pkg::POS_SF +: 2];
   assign fast_threshold_select = config_register_reg[afp_pkg::POS_FTH +: 3];
   assign watchdog_enable       = config_register_reg[afp_pkg::POS_WD];

   // Pin inputs pass two flip-flops before use.
   always_ff @(posedge core_clk)
   begin
      angle_s1_reg <= raw_angle;
      angle_s2_reg <= angle_s1_reg;
      field_s1_reg <= field_strength;
      field_s2_reg <= field_s1_reg;
   end

   // Register writes.
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         config_register_reg <= afp_pkg::CONFIG_RESET;
         min_field_level_reg <= afp_pkg::MIN_FIELD_RESET;
         irq_mask_reg        <= '0;
      end
      else if (reg_wr)
      begin
         if (reg_addr == afp_pkg::ADDR_CONFIG)
            config_register_reg <= reg_wdata;
         if (reg_addr == afp_pkg::ADDR_MIN_FIELD)
            min_field_level_reg <= reg_wdata[7:0];
         if (reg_addr == afp_pkg::ADDR_IRQ_MASK)
            irq_mask_reg <= reg_wdata[IRQ_W-1:0];
      end
   end

   // Sticky interrupt status; a new event wins over a write-one clear.
   always_ff @(posedge core_clk)
   begin
      if (srst)
         irq_status_reg <= '0;
      else if (reg_wr && reg_addr == afp_pkg::ADDR_IRQ_STATUS)
         irq_status_reg <= (irq_status_reg & ~reg_wdata[IRQ_W-1:0]) | irq_event;
      else
         irq_status_reg <= irq_status_reg | irq_event;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         irq <= 1'b0;
      else
         irq <= |(irq_status_reg & irq_mask_reg);
   end

   // Read data one cycle after the strobe; unmapped offsets read zero.
   always_ff @(posedge core_clk)
   begin
      if (srst)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         case (reg_addr)
            afp_pkg::ADDR_CONFIG:     reg_rdata <= config_register_reg;
            afp_pkg::ADDR_STATUS:     reg_rdata <= {10'h000, pwr_reg, fast_reg, magnet_reg};
            afp_pkg::ADDR_IRQ_STATUS: reg_rdata <= {12'h000, irq_status_reg};
            afp_pkg::ADDR_IRQ_MASK:   reg_rdata <= {12'h000, irq_mask_reg};
            afp_pkg::ADDR_MIN_FIELD:  reg_rdata <= {8'h00, min_field_level_reg};
            afp_pkg::ADDR_ANGLE:      reg_rdata <= {4'h0, quad_angle};
            default:                  reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

   // Filter update enable; the period is far below 1 ms so new settings apply promptly.
   always_ff @(posedge core_clk)
   begin
      if (srst || upd_tick)
         upd_cnt_reg <= 16'h0000;
      else
         upd_cnt_reg <= upd_cnt_reg + 16'h0001;
   end

   assign upd_tick = (upd_cnt_reg == 16'(afp_pkg::UPDATE_CYCLES - 1)); // R13

   // Threshold table.
   always_comb
   begin
      case (fast_threshold_select) // R4
         3'h1:    begin s2f_lsb = afp_pkg::S2F_001; f2s_lsb = afp_pkg::F2S_LOW;  end
         3'h2:    begin s2f_lsb = afp_pkg::S2F_010; f2s_lsb = afp_pkg::F2S_LOW;  end
         3'h3:    begin s2f_lsb = afp_pkg::S2F_011; f2s_lsb = afp_pkg::F2S_LOW;  end
         3'h4:    begin s2f_lsb = afp_pkg::S2F_100; f2s_lsb = afp_pkg::F2S_MID;  end
         3'h5:    begin s2f_lsb = afp_pkg::S2F_101; f2s_lsb = afp_pkg::F2S_MID;  end
         3'h6:    begin s2f_lsb = afp_pkg::S2F_110; f2s_lsb = afp_pkg::F2S_MID;  end
         3'h7:    begin s2f_lsb = afp_pkg::S2F_111; f2s_lsb = afp_pkg::F2S_HIGH; end
         default: begin s2f_lsb = 5'h1f;            f2s_lsb = 5'h00;            end
      endcase
   end

   // Shortest-path angular error between input and filter output.
   assign err     = angle_s2_reg - filt_value;
   assign err_abs = err[11] ? (12'h000 - err) : err;

   // Fast filter engage and release.
   always_comb
   begin
      fast_next = fast_reg;
      if (fast_threshold_select == 3'h0 || pwr_reg != afp_pkg::PWR_NORMAL) // R2 R10
         fast_next = 1'b0;
      else if (!fast_reg && err_abs > {7'h00, s2f_lsb}) // R3
         fast_next = 1'b1;
      else if (fast_reg && err_abs < {7'h00, f2s_lsb}) // R6
         fast_next = 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         fast_reg <= 1'b0;
      else if (upd_tick || fast_threshold_select == 3'h0 || pwr_reg != afp_pkg::PWR_NORMAL) // R2 R10
         fast_reg <= fast_next;
   end

   // Filter shift from the slow select or, while fast, the shortest setting.
   always_comb
   begin
      if (fast_reg)
         shift = afp_pkg::SHIFT_SF11; // R5
      else
      begin
         case (slow_filter_select) // R1
            2'h0:    shift = afp_pkg::SHIFT_SF00;
            2'h1:    shift = afp_pkg::SHIFT_SF01;
            2'h2:    shift = afp_pkg::SHIFT_SF10;
            default: shift = afp_pkg::SHIFT_SF11;
         endcase
      end
   end

   afp_stage u_stage
   (
      .core_clk (core_clk),
      .srst     (srst),
      .step_en  (upd_tick),
      .load     (1'b0),
      .sample   (angle_s2_reg),
      .shift    (shift),
      .value    (filt_value)
   );

   // Magnet detection.
   assign magnet_ok = (field_s2_reg >= min_field_level_reg);

   always_ff @(posedge core_clk)
   begin
      if (srst)
         magnet_reg <= 1'b0;
      else
         magnet_reg <= magnet_ok;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         magnet_present <= 1'b0;
      else
         magnet_present <= magnet_ok; // R8
   end

   // Output hysteresis.
   assign hysteresis_select_diff = filt_value - hold_reg;
   assign hysteresis_select_abs  = hysteresis_select_diff[11] ? (12'h000 - hysteresis_select_diff) : hysteresis_select_diff;
   assign hysteresis_select_lsb  = {10'h000, hysteresis_select}; // R14

   always_ff @(posedge core_clk)
   begin
      if (srst)
         hold_reg <= 12'h000;
      else if (hysteresis_select_abs > hysteresis_select_lsb) // R7
         hold_reg <= filt_value;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         quad_angle <= 12'h000;
      else if (magnet_ok) // R8
         quad_angle <= hold_reg;
   end

   // Watchdog stillness detection.
   assign wd_diff  = angle_s2_reg - wd_ref_reg;
   assign wd_abs   = wd_diff[11] ? (12'h000 - wd_diff) : wd_diff;
   assign wd_moved = (wd_abs > afp_pkg::WD_WINDOW_LSB);

   always_ff @(posedge core_clk)
   begin
      if (srst || !watchdog_enable || wd_moved)
      begin
         wd_ref_reg <= angle_s2_reg; // R15
         wd_cnt_reg <= 36'h000000000;
      end
      else if (wd_cnt_reg != 36'(WD_CYCLES))
         wd_cnt_reg <= wd_cnt_reg + 36'h000000001; // R11
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || !watchdog_enable || wd_moved)
         wd_sleep_reg <= 1'b0; // R15
      else if (wd_cnt_reg == 36'(WD_CYCLES))
         wd_sleep_reg <= 1'b1; // R11
   end

   // Power state machine.
   always_comb
   begin
      case (power_mode_select) // R12
         2'h0:    pwr_next = afp_pkg::PWR_NORMAL;
         2'h1:    pwr_next = afp_pkg::PWR_FIRST_LOW_POWER_MODE;
         2'h2:    pwr_next = afp_pkg::PWR_SECOND_LOW_POWER_MODE;
         default: pwr_next = afp_pkg::PWR_LPM3;
      endcase
      if (wd_sleep_reg)
         pwr_next = afp_pkg::PWR_LPM3; // R11
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         pwr_reg <= afp_pkg::PWR_NORMAL;
      else
         pwr_reg <= pwr_next; // R9
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         power_state <= 4'h1;
      else
         power_state <= pwr_reg;
   end

   // Interrupt events.
   assign irq_event[afp_pkg::IRQ_MAGNET_LOST]  = magnet_reg & ~magnet_ok;
   assign irq_event[afp_pkg::IRQ_MAGNET_FOUND] = ~magnet_reg & magnet_ok;
   assign irq_event[afp_pkg::IRQ_WD_SLEEP]     = ~wd_sleep_reg & watchdog_enable & ~wd_moved
                                                 & (wd_cnt_reg == 36'(WD_CYCLES));
   assign irq_event[afp_pkg::IRQ_FAST_ON]      = upd_tick & ~fast_reg & fast_next;

endmodule : afp_core

`default_nettype wire

// ### bench/afp_properties.sv
// Checker with the port-level properties of the angle filter block.
`timescale 1ns/100ps
`default_nettype none

module afp_properties
#(
   parameter longint unsigned WD_CYCLES = 2000
)
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [11:0] raw_angle,
   input wire logic [7:0]  field_strength,
   input wire logic [11:0] quad_angle,
   input wire logic        magnet_present,
   input wire logic [3:0]  power_state,
   input wire logic        irq
);
   logic [15:0] cfg_reg;
   logic [9:0]  age_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   always_ff @(posedge core_clk)
   begin
      if (srst)
         cfg_reg <= afp_pkg::CONFIG_RESET;
      else if (reg_wr && reg_addr == afp_pkg::ADDR_CONFIG)
         cfg_reg <= reg_wdata;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         age_reg <= 10'h3e8;
      else if (reg_wr && reg_addr == afp_pkg::ADDR_CONFIG)
         age_reg <= 10'h000;
      else if (age_reg != 10'h3e8)
         age_reg <= age_reg + 10'h001;
   end

   sequence stat_rd_s;
      reg_rd && reg_addr == afp_pkg::ADDR_STATUS;
   endsequence

   sequence lost_s;
      !magnet_present ##1 !magnet_present;
   endsequence

   power_onehot_a: assert property ($onehot(power_state))
      else $error("power state not one-hot");
   lost_freeze_a: assert property (lost_s |-> $stable(quad_angle))
      else $error("angle moved without magnet");
   angle_hold_a: assert property ($changed(quad_angle) && $past(magnet_present, 2) |=>
      $stable(quad_angle) [*8])
      else $error("angle changed off the update period");
   status_view_a: assert property (stat_rd_s |=>
      reg_rdata[0] == $past(magnet_present) && reg_rdata[5:2] == power_state)
      else $error("status read disagrees with ports");
   angle_view_a: assert property (reg_rd && reg_addr == afp_pkg::ADDR_ANGLE |=>
      reg_rdata == {4'h0, $past(quad_angle)})
      else $error("angle read disagrees with port");
   mode_map_a: assert property (age_reg == 10'h3e8 && !cfg_reg[13] |->
      power_state == 4'h1 << cfg_reg[1:0])
      else $error("power state does not follow mode select");
   slow_only_a: assert property (stat_rd_s ##0 (cfg_reg[12:10] == 3'h0 && age_reg == 10'h3e8) |=>
      !reg_rdata[1])
      else $error("fast filter on with threshold select zero");
   lp_no_fast_a: assert property (stat_rd_s ##0 (power_state != 4'h1 && $past(power_state) != 4'h1) |=>
      !reg_rdata[1])
      else $error("fast filter on in low power");
endmodule : afp_properties

bind afp_core afp_properties #(.WD_CYCLES(WD_CYCLES)) u_afp_properties
(
   .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_angle(raw_angle), .field_strength(field_strength),
   .quad_angle(quad_angle), .magnet_present(magnet_present), .power_state(power_state), .irq(irq)
);

`default_nettype wire

// ### bench/afp_core_tb.sv
// Self-checking testbench for the angle filter and power control block.
`timescale 1ns/100ps
`default_nettype none

module afp_core_tb;
   localparam int UPD = afp_pkg::UPDATE_CYCLES;
   logic        core_clk       = 1'b0;
   logic        srst           = 1'b1;
   logic [3:0]  reg_addr       = 4'h0;
   logic [15:0] reg_wdata      = 16'h0000;
   logic        reg_wr         = 1'b0;
   logic        reg_rd         = 1'b0;
   logic [15:0] reg_rdata;
   logic [11:0] raw_angle      = 12'h000;
   logic [7:0]  field_strength = 8'h10;
   logic [11:0] quad_angle;
   logic        magnet_present;
   logic [3:0]  power_state;
   logic        irq;
   int          errors         = 0;
   int          cmp_count      = 0;
   logic [15:0] d;
   logic        seen;
   logic [11:0] q0;

   always #20 core_clk = ~core_clk;

   afp_core #(.WD_CYCLES(2000)) u_afp_core
   (
      .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_angle(raw_angle), .field_strength(field_strength),
      .quad_angle(quad_angle), .magnet_present(magnet_present), .power_state(power_state), .irq(irq)
   );

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   task automatic stop_test;
      $display("compares %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask : rd

   task automatic cfg(input logic [1:0] pm, input logic [1:0] hy, input logic [1:0] sf, input logic [2:0] th,
                      input logic wd);
      wr(afp_pkg::ADDR_CONFIG, {2'h0, wd, th, sf, 4'h0, hy, pm});
   endtask : cfg

   task automatic upd(input int n);
      repeat (n * UPD) @(posedge core_clk);
   endtask : upd

   task automatic poll_fast(input int n);
      seen = 1'b0;
      repeat (n * 4)
      begin
         rd(afp_pkg::ADDR_STATUS);
         seen = seen | d[1];
         repeat (197) @(posedge core_clk);
      end
   endtask : poll_fast

   task automatic test_reset;
      check({4'h0, quad_angle}, 16'h0000);
      check({12'h0, power_state}, 16'h0001);
      check({14'h0, irq, magnet_present}, 16'h0000);
      rd(afp_pkg::ADDR_CONFIG);
      check(d, afp_pkg::CONFIG_RESET);
      rd(afp_pkg::ADDR_IRQ_MASK);
      check(d, 16'h0000);
      rd(afp_pkg::ADDR_MIN_FIELD);
      check(d, {8'h00, afp_pkg::MIN_FIELD_RESET});
      wr(4'hf, 16'hffff);
      rd(4'hf);
      check(d, 16'h0000);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_magnet;
      raw_angle <= 12'h123;
      upd(3);
      check({4'h0, quad_angle}, 16'h0000);
      rd(afp_pkg::ADDR_STATUS);
      check({15'h0, d[0]}, 16'h0000);
      wr(afp_pkg::ADDR_IRQ_MASK, 16'h0003);
      field_strength <= 8'h20;
      raw_angle      <= 12'h000;
      repeat (5) @(posedge core_clk);
      check({15'h0, magnet_present}, 16'h0001);
      repeat (3) @(posedge core_clk);
      check({15'h0, irq}, 16'h0001);
      wr(afp_pkg::ADDR_IRQ_STATUS, 16'h0002);
      repeat (3) @(posedge core_clk);
      check({15'h0, irq}, 16'h0000);
      field_strength <= 8'h1f;
      repeat (5) @(posedge core_clk);
      check({15'h0, magnet_present}, 16'h0000);
      repeat (2) @(posedge core_clk);
      check({15'h0, irq}, 16'h0001);
      rd(afp_pkg::ADDR_IRQ_STATUS);
      check(d, 16'h0001);
      wr(afp_pkg::ADDR_IRQ_MASK, 16'h0000);
      repeat (3) @(posedge core_clk);
      check({15'h0, irq}, 16'h0000);
      field_strength <= 8'h40;
      repeat (6) @(posedge core_clk);
      wr(afp_pkg::ADDR_IRQ_STATUS, 16'h0003);
      rd(afp_pkg::ADDR_IRQ_STATUS);
      check(d, 16'h0000);
      $display("test_magnet done");
   endtask : test_magnet

   task automatic test_slow;
      cfg(2'h0, 2'h0, 2'h3, 3'h0, 1'b0);
      raw_angle <= 12'h200;
      upd(12);
      check({15'h0, quad_angle > 12'h160}, 16'h0001);
      cfg(2'h0, 2'h0, 2'h0, 3'h0, 1'b0);
      raw_angle <= 12'h000;
      upd(12);
      check({15'h0, quad_angle > 12'h100}, 16'h0001);
      $display("test_slow done");
   endtask : test_slow

   task automatic test_fast;
      for (int c = 0; c < 8; c++)
      begin
         cfg(2'h0, 2'h0, 2'h0, 3'(c), 1'b0);
         raw_angle <= c[0] ? 12'h000 : 12'h200;
         poll_fast(3);
         check({15'h0, seen}, {15'h0, c != 0});
      end
      $display("test_fast done");
   endtask : test_fast

   task automatic test_modes;
      for (int m = 0; m < 4; m++)
      begin
         cfg(2'(m), 2'h0, 2'h0, 3'h1, 1'b0);
         raw_angle <= m[0] ? 12'h000 : 12'h200;
         upd(1);
         repeat (10) @(posedge core_clk);
         check({12'h0, power_state}, 16'h0001 << m);
         poll_fast(2);
         check({15'h0, seen}, {15'h0, m == 0});
         check({12'h0, d[5:2]}, 16'h0001 << m);
      end
      $display("test_modes done");
   endtask : test_modes

   task automatic test_wd;
      cfg(2'h0, 2'h0, 2'h3, 3'h0, 1'b0);
      raw_angle <= 12'h040;
      upd(26);
      wr(afp_pkg::ADDR_IRQ_MASK, 16'h0004);
      cfg(2'h0, 2'h0, 2'h3, 3'h0, 1'b1);
      for (int i = 0; i < 6 * UPD && power_state !== 4'h8; i++)
         @(posedge core_clk);
      check({12'h0, power_state}, 16'h0008);
      repeat (3) @(posedge core_clk);
      check({15'h0, irq}, 16'h0001);
      raw_angle <= 12'h080;
      upd(1);
      check({12'h0, power_state}, 16'h0001);
      cfg(2'h0, 2'h0, 2'h3, 3'h0, 1'b0);
      wr(afp_pkg::ADDR_IRQ_STATUS, 16'h0004);
      wr(afp_pkg::ADDR_IRQ_MASK, 16'h0000);
      $display("test_wd done");
   endtask : test_wd

   task automatic test_hysteresis_select;
      raw_angle <= 12'h040;
      upd(6);
      cfg(2'h0, 2'h3, 2'h3, 3'h0, 1'b0);
      repeat (4) @(posedge core_clk);
      q0 = quad_angle;
      raw_angle <= q0 + 12'h001;
      upd(6);
      check({4'h0, quad_angle}, {4'h0, q0});
      raw_angle <= 12'h080;
      upd(6);
      check({15'h0, quad_angle !== q0}, 16'h0001);
      $display("test_hysteresis_select done");
   endtask : test_hysteresis_select

   initial
   begin
      repeat (100000) @(posedge core_clk);
      errors++;
      stop_test();
   end

   initial
   begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      test_reset();
      test_magnet();
      test_slow();
      test_fast();
      test_modes();
      test_wd();
      test_hysteresis_select();
      stop_test();
   end
endmodule : afp_core_tb

`default_nettype wire
